//--- verilog/ebcp_seq.sv
// External bus cycle sequencer with timing registers and reference clock output.
// How it works
// - Every bus cycle runs setup, command, write setup, access, hold in that order; command, write setup and hold are skipped when their length is zero.
// - Phase lengths come from the selected chip select's timing configuration register.
// - With ready enabled, the external module can hold access past its programmed length until ready is seen.
// - Setup lasts one or two units, plus zero to three on window change.
// - Command delay is zero to three units; write setup is zero or one.
// - Access lasts one to thirty-two units; hold lasts zero to three.
// - A flop toggled by the system clock drives the reference clock pin at half its rate when the driver is enabled.
//
// Decided for this implementation: the plain strobed port and the address map.
`include "ebcp_map.svh"
module ebcp_seq (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	input  wire logic        req_valid,
	input  wire logic        req_write,
	input  wire logic        req_cs,
	input  wire logic [15:0] req_addr,
	input  wire logic [15:0] req_wdata,
	output logic             req_ready,
	output logic             done,
	output logic [15:0]      rdata,
	output logic [1:0]       bus_cs_n,
	output logic             bus_rd_n,
	output logic             bus_wr_n,
	output logic [15:0]      bus_addr,
	output logic [15:0]      bus_data_out,
	output logic             bus_data_oe,
	input  wire logic [15:0] bus_data_in,
	input  wire logic        bus_ready,
	output logic             bus_reference_clock_out
);

	ebcp_pkg::ebcp_state_t st;
	ebcp_pkg::ebcp_state_t next_st;
	ebcp_pkg::ebcp_req_t   req;
	ebcp_pkg::ebcp_tcfg_t  sel_cfg;
	logic                  ready_s;
	logic [15:0]           din_s;
	logic                  accept;
	logic                  unit_end;
	logic                  win_chg;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	ebcp_sync u_ready_sync (
		.mclk (mclk),
		.rst  (rst),
		.din  (bus_ready),
		.dout (ready_s)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_din
			ebcp_sync u_din_sync (
				.mclk (mclk),
				.rst  (rst),
				.din  (bus_data_in[gi]),
				.dout (din_s[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Phase helpers
	// ----------------------------------------------------------------
	function automatic ebcp_pkg::ebcp_phase_t after_phase(ebcp_pkg::ebcp_phase_t p,
		ebcp_pkg::ebcp_tcfg_t c);
		ebcp_pkg::ebcp_phase_t n;
		n = ebcp_pkg::EBCP_IDLE;
		case (p)
			ebcp_pkg::EBCP_SETUP: begin
				if (c.cmd_len != 2'h0) begin
					n = ebcp_pkg::EBCP_CMD;
				end else if (c.wsetup_len) begin
					n = ebcp_pkg::EBCP_WSETUP;
				end else begin
					n = ebcp_pkg::EBCP_ACCESS;
				end
			end
			ebcp_pkg::EBCP_CMD: begin
				n = c.wsetup_len ? ebcp_pkg::EBCP_WSETUP : ebcp_pkg::EBCP_ACCESS;
			end
			ebcp_pkg::EBCP_WSETUP: begin
				n = ebcp_pkg::EBCP_ACCESS;
			end
			ebcp_pkg::EBCP_ACCESS: begin
				n = (c.hold_len != 2'h0) ? ebcp_pkg::EBCP_HOLD : ebcp_pkg::EBCP_IDLE;
			end
			default: begin
				n = ebcp_pkg::EBCP_IDLE;
			end
		endcase
		return n;
	endfunction

	// Length of a phase in clock cycles, minus one.
	function automatic logic [4:0] phase_len_m1(ebcp_pkg::ebcp_phase_t p,
		ebcp_pkg::ebcp_tcfg_t c, logic ext);
		logic [4:0] l;
		l = 5'h00;
		case (p)
			ebcp_pkg::EBCP_SETUP: begin
				l = {4'h0, c.setup_two} + (ext ? {3'h0, c.setup_ext} : 5'h00);
			end
			ebcp_pkg::EBCP_CMD: begin
				l = {3'h0, c.cmd_len} - 5'h01;
			end
			ebcp_pkg::EBCP_ACCESS: begin
				l = c.access_len_m1;
			end
			ebcp_pkg::EBCP_HOLD: begin
				l = {3'h0, c.hold_len} - 5'h01;
			end
			default: begin
				l = 5'h00;
			end
		endcase
		return l;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	assign req      = '{valid: req_valid, write: req_write, cs: req_cs, addr: req_addr,
		wdata: req_wdata};
	assign sel_cfg  = st.tcfg[req.cs];
	assign accept   = req.valid && st.req_ready;
	assign win_chg  = st.win_valid && (req.addr[`EBCP_WIN_LSB +: 8] != st.last_win);
	assign unit_end = (st.cnt == 5'h00) &&
		!(st.phase == ebcp_pkg::EBCP_ACCESS && st.cur.ready_en && !ready_s);

	always_comb begin
		next_st      = st;
		next_st.done = 1'b0;

		if (reg_wr) begin
			case (reg_addr)
				`EBCP_ADDR_TCFG0: next_st.tcfg[0] = reg_wdata;
				`EBCP_ADDR_TCFG1: next_st.tcfg[1] = reg_wdata;
				`EBCP_ADDR_CTRL:  next_st.refclk_en = reg_wdata[`EBCP_CTRL_REFCLK_BIT];
				default:          next_st.refclk_en = st.refclk_en;
			endcase
		end
		next_st.reg_rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				`EBCP_ADDR_TCFG0: next_st.reg_rdata = {18'h0, st.tcfg[0][13:0]};
				`EBCP_ADDR_TCFG1: next_st.reg_rdata = {18'h0, st.tcfg[1][13:0]};
				`EBCP_ADDR_CTRL:  next_st.reg_rdata = {31'h0, st.refclk_en};
				`EBCP_ADDR_STATUS: begin
					next_st.reg_rdata[`EBCP_STAT_BUSY_BIT] = !st.req_ready;
					next_st.reg_rdata[`EBCP_STAT_PHASE_LSB +: 3] = st.phase;
					next_st.reg_rdata[`EBCP_STAT_READY_BIT] = ready_s;
				end
				default:          next_st.reg_rdata = 32'h0000_0000;
			endcase
		end

		// The reference clock is a flop-driven copy of the system clock at half its rate.
		next_st.refclk = st.refclk_en ? !st.refclk : 1'b0;

		case (st.phase)
			ebcp_pkg::EBCP_IDLE: begin
				if (accept) begin
					next_st.phase     = ebcp_pkg::EBCP_SETUP;
					next_st.cur       = sel_cfg;
					next_st.ext       = win_chg;
					next_st.cnt       = phase_len_m1(ebcp_pkg::EBCP_SETUP, sel_cfg, win_chg);
					next_st.write     = req.write;
					next_st.cs        = req.cs;
					next_st.wdata     = req.wdata;
					next_st.pins.addr = req.addr;
					next_st.last_win  = req.addr[`EBCP_WIN_LSB +: 8];
					next_st.win_valid = 1'b1;
				end
			end
			ebcp_pkg::EBCP_SETUP, ebcp_pkg::EBCP_CMD, ebcp_pkg::EBCP_WSETUP,
			ebcp_pkg::EBCP_ACCESS, ebcp_pkg::EBCP_HOLD: begin
				if (!unit_end) begin
					next_st.cnt = (st.cnt == 5'h00) ? 5'h00 : st.cnt - 5'h01;
				end else begin
					next_st.phase = after_phase(st.phase, st.cur);
					next_st.cnt   = phase_len_m1(next_st.phase, st.cur, st.ext);
					if (st.phase == ebcp_pkg::EBCP_ACCESS && !st.write) begin
						next_st.rdata = din_s;
					end
					if (next_st.phase == ebcp_pkg::EBCP_IDLE) begin
						next_st.done = 1'b1;
					end
				end
			end
			default: begin
				next_st.phase = ebcp_pkg::EBCP_IDLE;
			end
		endcase

		next_st.req_ready = (next_st.phase == ebcp_pkg::EBCP_IDLE);
		next_st.pins.cs_n = next_st.req_ready ? 2'b11 : ~(2'b01 << next_st.cs);
		next_st.pins.rd_n = !(next_st.phase == ebcp_pkg::EBCP_ACCESS && !next_st.write);
		next_st.pins.wr_n = !(next_st.phase == ebcp_pkg::EBCP_ACCESS && next_st.write);
		next_st.pins.doe  = next_st.write && (next_st.phase == ebcp_pkg::EBCP_WSETUP ||
			next_st.phase == ebcp_pkg::EBCP_ACCESS || next_st.phase == ebcp_pkg::EBCP_HOLD);
		next_st.pins.dout = next_st.wdata;
		next_st.a_len = (next_st.phase != st.phase) ? 6'h00 :
			((st.a_len == 6'h3F) ? st.a_len : st.a_len + 6'h01);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st           <= '0;
			st.tcfg[0]   <= `EBCP_TCFG_RESET;
			st.tcfg[1]   <= `EBCP_TCFG_RESET;
			st.refclk_en <= `EBCP_CTRL_RESET;
			st.req_ready <= 1'b1;
			st.pins.cs_n <= 2'b11;
			st.pins.rd_n <= 1'b1;
			st.pins.wr_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata               = st.reg_rdata;
	assign req_ready               = st.req_ready;
	assign done                    = st.done;
	assign rdata                   = st.rdata;
	assign bus_cs_n                = st.pins.cs_n;
	assign bus_rd_n                = st.pins.rd_n;
	assign bus_wr_n                = st.pins.wr_n;
	assign bus_addr                = st.pins.addr;
	assign bus_data_out            = st.pins.dout;
	assign bus_data_oe             = st.pins.doe;
	assign bus_reference_clock_out = st.refclk;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_cycle_start: assert property (@(posedge mclk) disable iff (rst)
		accept |=> st.phase == ebcp_pkg::EBCP_SETUP && !st.req_ready)
		else $error("accepted request did not start the setup phase");

	a_access_next: assert property (@(posedge mclk) disable iff (rst)
		(st.phase == ebcp_pkg::EBCP_ACCESS) |=> st.phase inside
		{ebcp_pkg::EBCP_ACCESS, ebcp_pkg::EBCP_HOLD, ebcp_pkg::EBCP_IDLE})
		else $error("access phase left to an illegal phase");

	a_cfg_pick: assert property (@(posedge mclk) disable iff (rst)
		accept |=> st.cur == $past(sel_cfg))
		else $error("cycle did not take the selected timing configuration");

	a_setup_len: assert property (@(posedge mclk) disable iff (rst)
		(st.phase == ebcp_pkg::EBCP_SETUP && next_st.phase != ebcp_pkg::EBCP_SETUP) |->
		st.a_len == {5'h00, st.cur.setup_two} + (st.ext ? {4'h0, st.cur.setup_ext} : 6'h00))
		else $error("setup phase length wrong");

	a_cmd_len: assert property (@(posedge mclk) disable iff (rst)
		(st.phase == ebcp_pkg::EBCP_CMD && next_st.phase != ebcp_pkg::EBCP_CMD) |->
		st.a_len + 6'h01 == {4'h0, st.cur.cmd_len})
		else $error("command delay length wrong");

	a_wsetup_len: assert property (@(posedge mclk) disable iff (rst)
		(st.phase == ebcp_pkg::EBCP_WSETUP) |=> st.phase == ebcp_pkg::EBCP_ACCESS)
		else $error("write setup phase longer than one unit");

	a_access_len: assert property (@(posedge mclk) disable iff (rst)
		(st.phase == ebcp_pkg::EBCP_ACCESS && next_st.phase != ebcp_pkg::EBCP_ACCESS) |->
		st.a_len >= {1'b0, st.cur.access_len_m1} &&
		(st.cur.ready_en || st.a_len == {1'b0, st.cur.access_len_m1}))
		else $error("access phase length wrong");

	a_hold_len: assert property (@(posedge mclk) disable iff (rst)
		(st.phase == ebcp_pkg::EBCP_HOLD && next_st.phase != ebcp_pkg::EBCP_HOLD) |->
		st.a_len + 6'h01 == {4'h0, st.cur.hold_len})
		else $error("hold phase length wrong");

	a_ready_wait: assert property (@(posedge mclk) disable iff (rst)
		(st.phase == ebcp_pkg::EBCP_ACCESS && st.cnt == 5'h00 && st.cur.ready_en &&
		!ready_s) |=> st.phase == ebcp_pkg::EBCP_ACCESS && !st.pins.rd_n == !st.write)
		else $error("access ended while ready inactive");

	a_ready_end: assert property (@(posedge mclk) disable iff (rst)
		(st.phase == ebcp_pkg::EBCP_ACCESS && st.cnt == 5'h00 &&
		(!st.cur.ready_en || ready_s)) |=> st.phase != ebcp_pkg::EBCP_ACCESS)
		else $error("access not ended after ready");

	a_refclk_run: assert property (@(posedge mclk) disable iff (rst)
		st.refclk_en ##1 st.refclk_en |-> st.refclk != $past(st.refclk))
		else $error("reference clock did not follow the system clock");

endmodule

//--- shared/ebcp_map.svh
// Register offsets, field positions, reset values and timing counts of the bus sequencer.
`ifndef EBCP_MAP_SVH
`define EBCP_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define EBCP_ADDR_TCFG0  8'h00
`define EBCP_ADDR_TCFG1  8'h04
`define EBCP_ADDR_CTRL   8'h08
`define EBCP_ADDR_STATUS 8'h0C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EBCP_CTRL_REFCLK_BIT    0
`define EBCP_STAT_BUSY_BIT      0
`define EBCP_STAT_PHASE_LSB     1
`define EBCP_STAT_READY_BIT     4
`define EBCP_WIN_LSB            8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EBCP_TCFG_RESET  32'h0000_07E0
`define EBCP_CTRL_RESET  1'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EBCP_MCLK_NS     10
`define EBCP_PTU_NS      10

`endif

//--- shared/ebcp_pkg.sv
// Types shared by the external bus cycle sequencer.
package ebcp_pkg;

	typedef enum logic [2:0] {
		EBCP_IDLE   = 3'b000,
		EBCP_SETUP  = 3'b001,
		EBCP_CMD    = 3'b010,
		EBCP_WSETUP = 3'b011,
		EBCP_ACCESS = 3'b100,
		EBCP_HOLD   = 3'b101
	} ebcp_phase_t;

	// Layout of chip_select_timing_config; lengths in phase_time_unit.
	typedef struct packed {
		logic [17:0] rsvd;
		logic        ready_en;
		logic [1:0]  hold_len;
		logic [4:0]  access_len_m1;
		logic        wsetup_len;
		logic [1:0]  cmd_len;
		logic        setup_two;
		logic [1:0]  setup_ext;
	} ebcp_tcfg_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        cs;
		logic [15:0] addr;
		logic [15:0] wdata;
	} ebcp_req_t;

	typedef struct packed {
		logic [1:0]  cs_n;
		logic        rd_n;
		logic        wr_n;
		logic [15:0] addr;
		logic [15:0] dout;
		logic        doe;
	} ebcp_pins_t;

	typedef struct packed {
		ebcp_phase_t     phase;
		logic [4:0]      cnt;
		ebcp_tcfg_t      cur;
		logic            ext;
		logic            write;
		logic            cs;
		logic [15:0]     wdata;
		logic [7:0]      last_win;
		logic            win_valid;
		ebcp_tcfg_t [1:0] tcfg;
		logic            refclk_en;
		logic            refclk;
		logic [31:0]     reg_rdata;
		logic [15:0]     rdata;
		logic            done;
		logic            req_ready;
		ebcp_pins_t      pins;
		logic [5:0]      a_len;
	} ebcp_state_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic out;
	} ebcp_sync_t;

endpackage

//--- verilog/ebcp_sync.sv
// Three-stage synchroniser whose output follows once stages two and three agree.
module ebcp_sync (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic din,
	output logic      dout
);

	ebcp_pkg::ebcp_sync_t st;
	ebcp_pkg::ebcp_sync_t next_st;

	always_comb begin
		next_st    = st;
		next_st.s1 = din;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		if (st.s2 == st.s3) begin
			next_st.out = st.s3;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign dout = st.out;

endmodule

//--- verif/ebcp_ext_mem.sv
// Behavioural memory that answers the sequencer on the far side of the external bus.
module ebcp_ext_mem (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [7:0]  stall_len,
	input  wire logic [1:0]  bus_cs_n,
	input  wire logic        bus_wr_n,
	input  wire logic [15:0] bus_addr,
	input  wire logic [15:0] bus_data_out,
	input  wire logic        bus_data_oe,
	output logic [15:0]      bus_data_in,
	output logic             bus_ready
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] mem [256];
	logic [15:0] last;
	logic [7:0]  cnt;
	logic        sel;
	logic        sel_d;

	assign sel = ~&bus_cs_n;
	// A deselected memory shows the inverse of its last value, so stale data cannot pass.
	assign bus_data_in = sel ? mem[bus_addr[7:0]] : ~last;
	assign bus_ready   = (cnt == 8'h00);

	initial begin
		last = 16'h0000;
		sel_d = 1'b0;
		for (int i = 0; i < 256; i++) begin
			mem[i] = 16'hA500 + 16'(i);
		end
	end

	// Ready is held low for stall_len cycles after each selection.
	always @(posedge mclk) begin
		sel_d <= sel;
		if (sel) begin
			last <= mem[bus_addr[7:0]];
		end
		if (rst) begin
			cnt <= 8'h00;
		end else if (sel && !sel_d) begin
			cnt <= stall_len;
		end else if (cnt != 8'h00) begin
			cnt <= cnt - 8'h01;
		end
		if (sel && !bus_wr_n && bus_data_oe) begin
			mem[bus_addr[7:0]] <= bus_data_out;
		end
	end
endmodule

//--- verif/tb_top.sv
// Self-checking testbench of the external bus cycle sequencer.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic        mclk;
	logic        rst;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        req_valid;
	logic        req_write;
	logic        req_cs;
	logic [15:0] req_addr;
	logic [15:0] req_wdata;
	logic        req_ready;
	logic        done;
	logic [15:0] rdata;
	logic [1:0]  bus_cs_n;
	logic        bus_rd_n;
	logic        bus_wr_n;
	logic [15:0] bus_addr;
	logic [15:0] bus_data_out;
	logic        bus_data_oe;
	logic [15:0] bus_data_in;
	logic        bus_ready;
	logic        refclk;
	logic [7:0]  stall_len;
	logic [31:0] d;
	logic        b0;
	int          n;
	int          acc_cnt;
	int          errors;
	int          checks;

	ebcp_seq dut_u (
		.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.req_valid(req_valid), .req_write(req_write), .req_cs(req_cs),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
		.done(done), .rdata(rdata), .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n),
		.bus_wr_n(bus_wr_n), .bus_addr(bus_addr), .bus_data_out(bus_data_out),
		.bus_data_oe(bus_data_oe), .bus_data_in(bus_data_in), .bus_ready(bus_ready),
		.bus_reference_clock_out(refclk)
	);

	ebcp_ext_mem p_u (
		.mclk(mclk), .rst(rst), .stall_len(stall_len), .bus_cs_n(bus_cs_n),
		.bus_wr_n(bus_wr_n), .bus_addr(bus_addr), .bus_data_out(bus_data_out),
		.bus_data_oe(bus_data_oe), .bus_data_in(bus_data_in), .bus_ready(bus_ready)
	);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Counts cycles with a command strobe low, which is the access phase length.
	always @(posedge mclk) begin
		if (!bus_rd_n || !bus_wr_n) begin
			acc_cnt++;
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	// Runs one bus cycle; cnt is the number of cycles from acceptance to done.
	task automatic bus_cycle(input logic w, input logic c, input logic [15:0] a,
		input logic [15:0] v, output int cnt);
		@(posedge mclk);
		req_valid <= 1'b1;
		req_write <= w;
		req_cs    <= c;
		req_addr  <= a;
		req_wdata <= v;
		@(posedge mclk);
		req_valid <= 1'b0;
		acc_cnt = 0;
		cnt = 0;
		do begin
			@(posedge mclk);
			#1 cnt++;
			if (cnt == 1) begin
				check("chip select", bus_cs_n, c ? 2'b01 : 2'b10);
				check("busy", req_ready, 1'b0);
				check("address", bus_addr, a);
			end
		end while (done !== 1'b1 && cnt < 200);
		check("idle again", req_ready, 1'b1);
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge mclk);
		errors++;
		print_verdict;
	end

	initial begin
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_cs = 1'b0;
		req_addr = 16'h0000;
		req_wdata = 16'h0000;
		stall_len = 8'h00;
		errors = 0;
		checks = 0;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		reg_read(8'h00, d);
		check("tcfg0 reset", d, 32'h0000_07E0);
		reg_read(8'h04, d);
		check("tcfg1 reset", d, 32'h0000_07E0);
		reg_read(8'h08, d);
		check("ctrl reset", d, 32'h0000_0000);
		reg_read(8'h10, d);
		check("unmapped read", d, 32'h0000_0000);
		reg_read(8'h0C, d);
		check("status idle", d, 32'h0000_0010);
		$display("test reset values done");
		// Ready is ignored while its enable is clear.
		stall_len <= 8'h28;
		bus_cycle(1'b0, 1'b0, 16'h0005, 16'h0000, n);
		check("default duration", n, 1 + 1 + 32);
		check("default access", acc_cnt, 32);
		check("default rdata", rdata, 16'hA505);
		stall_len <= 8'h00;
		$display("test default read done");
		// Longest setup, command, write setup and hold; window unchanged.
		reg_write(8'h00, 32'h0000_18FF);
		reg_read(8'h00, d);
		check("tcfg0 readback", d, 32'h0000_18FF);
		bus_cycle(1'b1, 1'b0, 16'h0010, 16'hBEEF, n);
		check("full duration", n, 2 + 3 + 1 + 4 + 3);
		check("full access", acc_cnt, 4);
		check("written word", p_u.mem[8'h10], 16'hBEEF);
		bus_cycle(1'b0, 1'b0, 16'h0010, 16'h0000, n);
		check("readback duration", n, 2 + 3 + 1 + 4 + 3);
		check("readback rdata", rdata, 16'hBEEF);
		$display("test phase lengths done");
		// Window change adds the extension once only.
		reg_write(8'h04, 32'h0000_0003);
		bus_cycle(1'b1, 1'b1, 16'h1234, 16'h1111, n);
		check("window change", n, (1 + 3) + 1);
		bus_cycle(1'b1, 1'b1, 16'h1256, 16'h2222, n);
		check("same window", n, 1 + 1);
		check("access one", acc_cnt, 1);
		check("window word", p_u.mem[8'h56], 16'h2222);
		$display("test address window done");
		// Ready held low by the memory stretches access.
		reg_write(8'h04, 32'h0000_21C0);
		stall_len <= 8'h14;
		bus_cycle(1'b0, 1'b1, 16'h1260, 16'h0000, n);
		check("stretched", (n >= 22 && n <= 32) ? 1'b1 : 1'b0, 1'b1);
		check("stretched rdata", rdata, 16'hA560);
		stall_len <= 8'h00;
		$display("test ready stretch done");
		reg_write(8'h08, 32'h0000_0001);
		@(posedge mclk);
		#1 b0 = refclk;
		@(posedge mclk);
		#1 check("refclk toggle", refclk ^ b0, 1'b1);
		reg_write(8'h08, 32'h0000_0000);
		repeat (2) @(posedge mclk);
		#1 check("refclk off", refclk, 1'b0);
		$display("test reference clock done");
		print_verdict;
	end
endmodule
